// ### rtl/rtc_core.sv
// Operation
// RQ1: host sets meridiem bit in 24-hour alarms
// RQ2: frequency pin is AND of selected clocks
// RQ3: low three frequency bits are plain storage
// RQ4: 1 Hz output edges align with seconds
// RQ5: host keeps correction byte zero if unused
// RQ6: scratch byte stores and returns any value
// RQ7: reset and init load calendar start date
// RQ8: power-on loads fixed register values
// RQ9: power-on sets flag, outputs 1 Hz
// RQ10: init clears power flag and frequency mode
// RQ11: init keeps status1 bits 6-4, clears rest; the code loads bits 6-4 from the init write data
// RQ12: supply sampled once per second, short window
// RQ13: low supply flag sticks, sampling stops
// RQ14: low supply flag never initializes state
// RQ15: read flag may clear after next sample
// RQ16: bad year, month, day, weekday get corrected
// RQ17: bad hour, minute written become zero
// RQ18: bad second fixed at next tick, carries
// RQ19: day past month end becomes next first
// RQ20: 24-hour meridiem reads from hour value
// RQ21: host places alarm and mode settings
// RQ22: alarm two pulls pin low always
// RQ23: host clears alarm byte before mode switch
// RQ24: timed modes need no alarm contents
// RQ25: status2 upper bits choose pin mode
// RQ26: alarm bytes compared only when enabled
// RQ27: power flag read-only, clears on read
// RQ28: init bit write-only, reads zero
// RQ29: frequency mode with none selected stays high
`timescale 1ns/1ps
`default_nettype none
module rtc_core import rtc_pkg::*; (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// oscillator: one pulse per half period of 32.768 kHz
	input  wire logic       osc_tick_i,
	// supply monitor
	input  wire logic       supply_low_i,
	output logic            lows_sample_o,
	// register port
	input  wire logic [4:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	// interrupt pin, active low
	output logic            int_b_o
);
	typedef struct packed {
		logic [7:0]      yr;
		logic [7:0]      mon;
		logic [7:0]      day;
		logic [2:0]      wd;
		logic [7:0]      hr;
		logic [7:0]      mi;
		logic [7:0]      se;
		logic [15:0]     pre;
		logic            pwr_f;
		logic            lows_f;
		logic            lows_rearm;
		logic            lows_skip;
		logic            a1_f;
		logic            a2_f;
		logic [2:0]      st1_rw;
		logic [7:0]      st2;
		logic [2:0][7:0] a1;
		logic [2:0][7:0] a2;
		logic [7:0]      corr;
		logic [7:0]      scr;
		logic            a1_act;
		logic            a2_act;
		logic            a1_prev;
		logic            a2_prev;
		logic            armed;
		mode_t           mode_prev;
		logic [9:0]      mp_cnt;
		logic [7:0]      rdata;
		logic            int_b;
	} state_t;

	logic [1:0] rst_sync_b_r;
	logic       rst_b;
	state_t     st_r;
	state_t     st_nxt;
	mode_t      mode;
	logic       mode24;
	logic       sec_tick;
	logic       min_ev;
	logic       hr_ev;
	logic       day_ev;
	logic       init;
	logic       m1;
	logic       m2;
	logic       lvl;
	logic [7:0] rd_mux;
	logic [7:0] hr_inc;

	function automatic logic bcd_bad(input logic [7:0] v);
		return (v[3:0] > 4'h9) || (v[7:4] > 4'h9);
	endfunction

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// leap when the two-digit year is a multiple of four
	function automatic logic leap(input logic [7:0] y);
		return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
		            : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
		logic [7:0] r;
		r = DAY_MAX;
		if (m == 8'h02) begin
			r = leap(y) ? 8'h29 : 8'h28;
		end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
			r = 8'h30;
		end
		return r;
	endfunction

	// alarm match over enabled bytes only
	function automatic logic alarm_match(input logic [2:0][7:0] a, input state_t s,
	                                     input logic h24);
		logic hok;
		hok = h24 ? (a[1][6:1] == s.hr[5:0]) : (a[1][7:1] == s.hr[6:0]);
		return (a[0][0] | a[1][0] | a[2][0]) &&
		       (!a[0][0] || a[0][3:1] == s.wd) &&
		       (!a[1][0] || hok) &&
		       (!a[2][0] || a[2][7:1] == s.mi[6:0]);
	endfunction

	// reset release through two flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_b_r <= 2'b00;
		end else begin
			rst_sync_b_r <= {rst_sync_b_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_b_r[1];

	// pin mode decode
	always_comb begin
		mode = MODE_NONE;
		if (st_r.st2[ST2_B_XTAL]) begin
			mode = MODE_XTAL;
		end else begin
			// item order: alarm one, minute, frequency enables
			case ({st_r.st2[ST2_B_A1EN], st_r.st2[ST2_B_MIN], st_r.st2[ST2_B_FREQ]}) // [RQ25]
				3'b001, 3'b101: mode = MODE_FREQ;
				3'b010, 3'b110: mode = MODE_MEDGE;
				3'b011:         mode = MODE_MCLK;
				3'b100:         mode = MODE_ALARM;
				3'b111:         mode = MODE_MPULSE;
				default:        mode = MODE_NONE;
			endcase
		end
	end

	assign mode24 = st_r.st1_rw[ST1_B_MODE24 - 4];
	assign init   = wr_i && addr_i == IDX_ST1 && wdata_i[ST1_B_INIT]; // [RQ28]
	assign m1     = alarm_match(st_r.a1, st_r, mode24); // [RQ26]
	assign m2     = alarm_match(st_r.a2, st_r, mode24);
	assign hr_inc = bcd_inc({2'b00, st_r.hr[5:0]});
	// a window cut short by init is skipped until the next second
	assign lows_sample_o = (st_r.pre < LOWV_WIN_TICKS) && !st_r.lows_f && !st_r.lows_skip; // [RQ12]

	// read mux
	always_comb begin
		rd_mux = BYTE_CLR;
		if (addr_i == IDX_YEAR) begin
			rd_mux = st_r.yr;
		end else if (addr_i == IDX_MON) begin
			rd_mux = st_r.mon;
		end else if (addr_i == IDX_DAY) begin
			rd_mux = st_r.day;
		end else if (addr_i == IDX_WDAY) begin
			rd_mux = {5'h00, st_r.wd};
		end else if (addr_i == IDX_HOUR) begin
			rd_mux = mode24 ? {1'b0, st_r.hr[5:0] >= 6'h12, st_r.hr[5:0]} // [RQ20]
			                : {1'b0, st_r.hr[6:0]};
		end else if (addr_i == IDX_MIN) begin
			rd_mux = st_r.mi;
		end else if (addr_i == IDX_SEC) begin
			rd_mux = st_r.se;
		end else if (addr_i == IDX_ST1) begin
			rd_mux = {1'b0, st_r.st1_rw, st_r.a1_f, st_r.a2_f, st_r.lows_f, st_r.pwr_f};
		end else if (addr_i == IDX_ST2) begin
			rd_mux = st_r.st2;
		end else if (addr_i >= IDX_A1 && addr_i < IDX_A2) begin
			rd_mux = st_r.a1[2'(addr_i - IDX_A1)]; // [RQ3]
		end else if (addr_i >= IDX_A2 && addr_i < IDX_CORR) begin
			rd_mux = st_r.a2[2'(addr_i - IDX_A2)];
		end else if (addr_i == IDX_CORR) begin
			rd_mux = st_r.corr;
		end else if (addr_i == IDX_SCRATCH) begin
			rd_mux = st_r.scr; // [RQ6]
		end
	end

	// next state
	always_comb begin
		st_nxt   = st_r;
		sec_tick = osc_tick_i && st_r.pre == PRE_WRAP;
		min_ev   = 1'b0;
		hr_ev    = 1'b0;
		day_ev   = 1'b0;
		lvl      = 1'b1;
		if (osc_tick_i) begin
			st_nxt.pre = st_r.pre + 16'h0001; // [RQ4]
		end
		// time counting
		if (sec_tick) begin
			if (st_r.se >= SEC_MAX || bcd_bad(st_r.se)) begin
				st_nxt.se = BYTE_CLR; // [RQ18]
				min_ev    = 1'b1;
			end else begin
				st_nxt.se = bcd_inc(st_r.se);
			end
		end
		if (min_ev) begin
			if (st_r.mi == SEC_MAX) begin
				st_nxt.mi = BYTE_CLR;
				hr_ev     = 1'b1;
			end else begin
				st_nxt.mi = bcd_inc(st_r.mi);
			end
		end
		if (hr_ev) begin
			if (mode24 && {2'b00, st_r.hr[5:0]} == HOUR24_MAX) begin
				st_nxt.hr = BYTE_CLR;
				day_ev    = 1'b1;
			end else if (!mode24 && {2'b00, st_r.hr[5:0]} == HOUR12_MAX) begin
				st_nxt.hr = {1'b0, !st_r.hr[6], 6'h00};
				day_ev    = st_r.hr[6];
			end else begin
				st_nxt.hr = {1'b0, st_r.hr[6], hr_inc[5:0]};
			end
		end
		if (day_ev) begin
			st_nxt.wd = (st_r.wd == 3'h6) ? CAL_WDAY_INIT : st_r.wd + 3'h1;
			if (st_r.day >= month_len(st_r.mon, st_r.yr)) begin
				st_nxt.day = CAL_DAY_INIT;
				if (st_r.mon == MON_MAX) begin
					st_nxt.mon = CAL_MON_INIT;
					st_nxt.yr  = (st_r.yr == YEAR_MAX) ? CAL_YEAR_INIT : bcd_inc(st_r.yr);
				end else begin
					st_nxt.mon = bcd_inc(st_r.mon);
				end
			end else begin
				st_nxt.day = bcd_inc(st_r.day);
			end
		end
		// register writes with validation
		if (wr_i) begin
			if (addr_i == IDX_YEAR) begin
				st_nxt.yr = bcd_bad(wdata_i) ? CAL_YEAR_INIT : wdata_i; // [RQ16]
			end else if (addr_i == IDX_MON) begin
				st_nxt.mon = (wdata_i == BYTE_CLR || wdata_i > MON_MAX || bcd_bad(wdata_i))
				             ? CAL_MON_INIT : wdata_i; // [RQ16]
			end else if (addr_i == IDX_DAY) begin
				st_nxt.day = (wdata_i == BYTE_CLR || wdata_i > DAY_MAX || bcd_bad(wdata_i))
				             ? CAL_DAY_INIT : wdata_i; // [RQ16]
			end else if (addr_i == IDX_WDAY) begin
				st_nxt.wd = (wdata_i[2:0] == 3'h7) ? CAL_WDAY_INIT : wdata_i[2:0]; // [RQ16]
			end else if (addr_i == IDX_HOUR) begin
				if (mode24) begin
					st_nxt.hr = ({2'b00, wdata_i[5:0]} > HOUR24_MAX ||
					             bcd_bad({2'b00, wdata_i[5:0]}))
					            ? BYTE_CLR : {2'b00, wdata_i[5:0]}; // [RQ17] [RQ20]
				end else begin
					st_nxt.hr = ({2'b00, wdata_i[5:0]} > HOUR12_MAX ||
					             bcd_bad({2'b00, wdata_i[5:0]}))
					            ? {1'b0, wdata_i[6], 6'h00} : {1'b0, wdata_i[6:0]}; // [RQ17]
				end
			end else if (addr_i == IDX_MIN) begin
				st_nxt.mi = ({1'b0, wdata_i[6:0]} > SEC_MAX || bcd_bad({1'b0, wdata_i[6:0]}))
				            ? BYTE_CLR : {1'b0, wdata_i[6:0]}; // [RQ17]
			end else if (addr_i == IDX_SEC) begin
				st_nxt.se = {1'b0, wdata_i[6:0]}; // [RQ18]
			end else if (addr_i == IDX_ST1) begin
				st_nxt.st1_rw = wdata_i[6:4];
			end else if (addr_i == IDX_ST2) begin
				st_nxt.st2 = wdata_i;
			end else if (addr_i >= IDX_A1 && addr_i < IDX_A2) begin
				st_nxt.a1[2'(addr_i - IDX_A1)] = wdata_i; // [RQ3]
			end else if (addr_i >= IDX_A2 && addr_i < IDX_CORR) begin
				st_nxt.a2[2'(addr_i - IDX_A2)] = wdata_i;
			end else if (addr_i == IDX_CORR) begin
				st_nxt.corr = wdata_i;
			end else if (addr_i == IDX_SCRATCH) begin
				st_nxt.scr = wdata_i; // [RQ6]
			end
		end
		// day beyond month end rolls to next month
		if (st_nxt.day > month_len(st_nxt.mon, st_nxt.yr)) begin
			st_nxt.day = CAL_DAY_INIT; // [RQ19]
			st_nxt.mon = bcd_inc(st_nxt.mon);
		end
		// reads: registered data, clear-on-read flags
		st_nxt.rdata = rd_i ? rd_mux : BYTE_CLR; // [RQ28]
		if (rd_i && addr_i == IDX_ST1) begin
			st_nxt.pwr_f = 1'b0; // [RQ27]
			st_nxt.a1_f  = 1'b0;
			st_nxt.a2_f  = 1'b0;
			if (st_r.lows_f) begin
				st_nxt.lows_rearm = 1'b1; // [RQ15]
			end
		end
		// low supply sampling; flag never starts init
		if (sec_tick) begin
			st_nxt.lows_skip = 1'b0; // [RQ12]
		end
		if (sec_tick && st_r.lows_rearm) begin
			st_nxt.lows_f     = 1'b0; // [RQ15]
			st_nxt.lows_rearm = 1'b0;
		end
		if (lows_sample_o && supply_low_i) begin
			st_nxt.lows_f = 1'b1; // [RQ13] [RQ14]
		end
		// alarms: latch on match rise, drop when disabled
		st_nxt.a1_prev = m1;
		st_nxt.a2_prev = m2;
		st_nxt.a1_act  = (mode == MODE_ALARM) && (st_r.a1_act || (m1 && !st_r.a1_prev));
		st_nxt.a2_act  = st_r.st2[ST2_B_A2EN] && (st_r.a2_act || (m2 && !st_r.a2_prev));
		if (mode == MODE_ALARM && m1 && !st_r.a1_prev) begin
			st_nxt.a1_f = 1'b1;
		end
		if (st_r.st2[ST2_B_A2EN] && m2 && !st_r.a2_prev) begin
			st_nxt.a2_f = 1'b1;
		end
		// minute-based modes arm at first minute carry after selection
		st_nxt.mode_prev = mode;
		if (mode != st_r.mode_prev) begin
			st_nxt.armed = 1'b0;
		end
		if (min_ev) begin
			st_nxt.armed  = 1'b1; // [RQ24]
			st_nxt.mp_cnt = MPULSE_TICKS;
		end else if (osc_tick_i && st_r.mp_cnt != 10'h000) begin
			st_nxt.mp_cnt = st_r.mp_cnt - 10'h001;
		end
		// pin level per mode
		case (mode)
			MODE_XTAL:   lvl = st_r.pre[0]; // [RQ24]
			MODE_FREQ:   lvl = &(~st_r.a1[0][7:3] | st_nxt.pre[15:11]); // [RQ2] [RQ4] [RQ29]
			MODE_MEDGE:  lvl = !st_r.armed;
			MODE_MCLK:   lvl = !(st_r.armed && st_r.se < HALF_MIN);
			MODE_ALARM:  lvl = !st_r.a1_act;
			MODE_MPULSE: lvl = !(st_r.armed && st_r.mp_cnt != 10'h000);
			default:     lvl = 1'b1;
		endcase
		st_nxt.int_b = lvl && !st_r.a2_act; // [RQ22]
		// software initialization
		if (init) begin
			st_nxt.yr     = CAL_YEAR_INIT; // [RQ7]
			st_nxt.mon    = CAL_MON_INIT;
			st_nxt.day    = CAL_DAY_INIT;
			st_nxt.wd     = CAL_WDAY_INIT;
			st_nxt.hr     = BYTE_CLR;
			st_nxt.mi     = BYTE_CLR;
			st_nxt.se     = BYTE_CLR;
			st_nxt.pwr_f  = 1'b0; // [RQ10] [RQ11]
			st_nxt.lows_f = 1'b0;
			st_nxt.lows_rearm = 1'b0;
			st_nxt.lows_skip  = 1'b1; // [RQ12]
			st_nxt.a1_f   = 1'b0;
			st_nxt.a2_f   = 1'b0;
			st_nxt.st2    = BYTE_CLR;
			st_nxt.a1     = '0;
			st_nxt.a2     = '0;
			st_nxt.corr   = BYTE_CLR;
			st_nxt.scr    = BYTE_CLR;
			st_nxt.a1_act = 1'b0;
			st_nxt.a2_act = 1'b0;
		end
	end

	// state register; power-on values
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			st_r        <= '0;
			st_r.mon    <= CAL_MON_INIT; // [RQ7]
			st_r.day    <= CAL_DAY_INIT;
			st_r.pwr_f  <= 1'b1; // [RQ8] [RQ9]
			st_r.st1_rw <= ST1_RW_POR;
			st_r.st2    <= ST2_POR;
			st_r.a1[0]  <= A1_POR;
			st_r.mode_prev <= MODE_FREQ;
			st_r.int_b  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign int_b_o = st_r.int_b;

	property p_init_clears;
		@(posedge clk_i) disable iff (!rst_b)
		init |=> (st_r.st2 == BYTE_CLR && st_r.scr == BYTE_CLR && st_r.a1 == '0 &&
		          st_r.day == CAL_DAY_INIT && !st_r.pwr_f && st_r.st1_rw == $past(wdata_i[6:4]));
	endproperty
	a_init_clears: assert property (p_init_clears) // [RQ11]
		else $error("init did not clear registers");

	property p_pwr_read;
		@(posedge clk_i) disable iff (!rst_b)
		(rd_i && addr_i == IDX_ST1) |=> !st_r.pwr_f && !rdata_o[ST1_B_INIT];
	endproperty
	a_pwr_read: assert property (p_pwr_read) // [RQ27]
		else $error("power flag or init bit wrong after read");

	property p_scratch;
		@(posedge clk_i) disable iff (!rst_b)
		(wr_i && addr_i == IDX_SCRATCH) ##1 (rd_i && addr_i == IDX_SCRATCH)
		|=> rdata_o == $past(wdata_i, 2);
	endproperty
	a_scratch: assert property (p_scratch) // [RQ6]
		else $error("scratch byte readback mismatch");

	property p_spare;
		@(posedge clk_i) disable iff (!rst_b)
		(wr_i && addr_i == IDX_A1) ##1 (rd_i && addr_i == IDX_A1)
		|=> rdata_o[2:0] == $past(wdata_i[2:0], 2);
	endproperty
	a_spare: assert property (p_spare) // [RQ3]
		else $error("spare frequency bits lost");

	property p_freq_idle;
		@(posedge clk_i) disable iff (!rst_b)
		(mode == MODE_FREQ && st_r.a1[0][7:3] == 5'h00 && !st_r.a2_act) |=> int_b_o;
	endproperty
	a_freq_idle: assert property (p_freq_idle) // [RQ29]
		else $error("pin low with no frequency selected");

	property p_one_hz;
		@(posedge clk_i) disable iff (!rst_b)
		(sec_tick && mode == MODE_FREQ && st_r.a1[0][7:3] == 5'h10 && !st_r.a2_act && !wr_i)
		|=> !int_b_o && st_r.se != $past(st_r.se);
	endproperty
	a_one_hz: assert property (p_one_hz) // [RQ4]
		else $error("1 Hz edge not aligned with seconds");

	property p_alarm2;
		@(posedge clk_i) disable iff (!rst_b)
		st_r.a2_act |=> !int_b_o;
	endproperty
	a_alarm2: assert property (p_alarm2) // [RQ22]
		else $error("alarm two did not pull pin low");

	property p_lows_hold;
		@(posedge clk_i) disable iff (!rst_b)
		(st_r.lows_f && !st_r.lows_rearm && !init) |=> st_r.lows_f && !lows_sample_o;
	endproperty
	a_lows_hold: assert property (p_lows_hold) // [RQ13]
		else $error("low supply flag dropped");

	property p_lows_window;
		@(posedge clk_i) disable iff (!rst_b)
		$rose(lows_sample_o) |-> st_r.pre == 16'h0000;
	endproperty
	a_lows_window: assert property (p_lows_window) // [RQ12]
		else $error("sampling window not at second start");

	property p_wday_fix;
		@(posedge clk_i) disable iff (!rst_b)
		(wr_i && addr_i == IDX_WDAY && wdata_i[2:0] == 3'h7) |=> st_r.wd == CAL_WDAY_INIT;
	endproperty
	a_wday_fix: assert property (p_wday_fix) // [RQ16]
		else $error("weekday seven not corrected");

endmodule // rtc_core
`default_nettype wire

// ### rtl/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
	// register indices
	localparam logic [4:0] IDX_YEAR    = 5'h00;
	localparam logic [4:0] IDX_MON     = 5'h01;
	localparam logic [4:0] IDX_DAY     = 5'h02;
	localparam logic [4:0] IDX_WDAY    = 5'h03;
	localparam logic [4:0] IDX_HOUR    = 5'h04;
	localparam logic [4:0] IDX_MIN     = 5'h05;
	localparam logic [4:0] IDX_SEC     = 5'h06;
	localparam logic [4:0] IDX_ST1     = 5'h07;
	localparam logic [4:0] IDX_ST2     = 5'h08;
	localparam logic [4:0] IDX_A1      = 5'h09;
	localparam logic [4:0] IDX_A2      = 5'h0C;
	localparam logic [4:0] IDX_CORR    = 5'h0F;
	localparam logic [4:0] IDX_SCRATCH = 5'h10;
	// status register 1 fields
	localparam int ST1_B_PWR   = 0;
	localparam int ST1_B_LOWS  = 1;
	localparam int ST1_B_A2    = 2;
	localparam int ST1_B_A1    = 3;
	localparam int ST1_B_MODE24 = 6;
	localparam int ST1_B_INIT  = 7;
	// status register 2 fields
	localparam int ST2_B_A2EN  = 1;
	localparam int ST2_B_XTAL  = 4;
	localparam int ST2_B_A1EN  = 5;
	localparam int ST2_B_MIN   = 6;
	localparam int ST2_B_FREQ  = 7;
	// reset and init values
	localparam logic [2:0] ST1_RW_POR  = 3'h0;
	localparam logic [7:0] ST2_POR     = 8'h80;
	localparam logic [7:0] A1_POR      = 8'h80;
	localparam logic [7:0] BYTE_CLR    = 8'h00;
	localparam logic [7:0] CAL_YEAR_INIT = 8'h00;
	localparam logic [7:0] CAL_MON_INIT  = 8'h01;
	localparam logic [7:0] CAL_DAY_INIT  = 8'h01;
	localparam logic [2:0] CAL_WDAY_INIT = 3'h0;
	// calendar limits (bcd)
	localparam logic [7:0] SEC_MAX   = 8'h59;
	localparam logic [7:0] HOUR24_MAX = 8'h23;
	localparam logic [7:0] HOUR12_MAX = 8'h11;
	localparam logic [7:0] MON_MAX   = 8'h12;
	localparam logic [7:0] DAY_MAX   = 8'h31;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [7:0] HALF_MIN  = 8'h30;
	// timing in oscillator half periods
	localparam int         OSC_HALF_HZ   = 65536;
	localparam int         LOWV_WIN_US   = 15600;
	localparam logic [15:0] LOWV_WIN_TICKS = 16'(LOWV_WIN_US * OSC_HALF_HZ / 1000000);
	localparam int         MPULSE_US     = 7810;
	localparam logic [9:0] MPULSE_TICKS  = 10'(MPULSE_US * OSC_HALF_HZ / 1000000);
	localparam logic [15:0] PRE_WRAP     = 16'hFFFF;
	// pin output modes
	typedef enum logic [2:0] {
		MODE_NONE   = 3'b000,
		MODE_FREQ   = 3'b001,
		MODE_MEDGE  = 3'b011,
		MODE_MCLK   = 3'b010,
		MODE_ALARM  = 3'b110,
		MODE_MPULSE = 3'b111,
		MODE_XTAL   = 3'b101
	} mode_t;
endpackage
`default_nettype wire

// ### sim/osc_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
// oscillator tick source and supply comparator facing the block
module osc_supply_model #(
	parameter int DIV = 1
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// supply sag asked for by the bench
	input  wire logic sag_i,
	// toward the block
	output logic      tick_o,
	output logic      supply_low_o
);
	int cnt_r;

	// one tick every DIV cycles, supply level lags sag by a cycle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r        <= 0;
			tick_o       <= 1'b0;
			supply_low_o <= 1'b0;
		end else begin
			cnt_r        <= (cnt_r >= DIV - 1) ? 0 : cnt_r + 1;
			tick_o       <= (cnt_r >= DIV - 1);
			supply_low_o <= sag_i;
		end
	end
endmodule // osc_supply_model
`default_nettype wire

// ### sim/rtc_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_core_bench import rtc_pkg::*; ;
	logic        clk, rst_b, tick, slow, sag, wr, rd, smp, pin;
	logic [4:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [15:0] win_cnt;
	int          n_mismatch, checked;
	// power-on register image, last entry unmapped
	logic [4:0] por_a [17] = '{IDX_YEAR, IDX_MON, IDX_DAY, IDX_WDAY, IDX_HOUR, IDX_MIN,
		IDX_SEC, IDX_ST2, IDX_A1, 5'h0A, 5'h0B, IDX_A2, 5'h0D, 5'h0E, IDX_CORR,
		IDX_SCRATCH, 5'h1F};
	logic [7:0] por_v [17] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80,
		8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// bad calendar writes and their corrected read-back, plus a valid 24-hour hour 22
	logic [4:0] cal_a [13] = '{IDX_YEAR, IDX_MON, IDX_MON, IDX_MON, IDX_DAY, IDX_DAY,
		IDX_WDAY, IDX_HOUR, IDX_MIN, IDX_MIN, IDX_HOUR, IDX_HOUR, IDX_HOUR};
	logic [7:0] cal_w [13] = '{8'h9A, 8'h13, 8'h00, 8'h1A, 8'h32, 8'h00, 8'h07, 8'h12,
		8'h60, 8'h7A, 8'h24, 8'h22, 8'h45};
	logic [7:0] cal_e [13] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h62, 8'h05};

	rtc_core DUT (
		.clk_i(clk), .rst_b_i(rst_b), .osc_tick_i(tick), .supply_low_i(slow),
		.lows_sample_o(smp), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .int_b_o(pin)
	);
	osc_supply_model #(.DIV(1)) osc (
		.clk_i(clk), .rst_b_i(rst_b), .sag_i(sag), .tick_o(tick), .supply_low_o(slow)
	);

	// clock
	always #2 clk = ~clk;

	// cycles spent sampling the supply
	always @(posedge clk) begin
		if (rst_b && smp === 1'b1) win_cnt <= win_cnt + 16'd1;
	end

	task automatic close_out();
		if (n_mismatch == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmpn(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t count=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	// write then read back with no idle cycle between strobes
	task automatic wr_chk(input logic [4:0] a, input logic [7:0] w, input logic [7:0] e);
		@(posedge clk);
		addr  <= a;
		wdata <= w;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		rd    <= 1'b1;
		@(posedge clk);
		rd    <= 1'b0;
		#1 cmp8(rdata, e);
	endtask

	task automatic chk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		cmp8(d, e);
	endtask

	// low cycles of the pin over n cycles, after the pin settles
	task automatic low_cnt(input int n, output logic [15:0] c);
		c = 16'd0;
		repeat (4) @(posedge clk);
		repeat (n) begin
			@(posedge clk);
			if (pin === 1'b0) c = c + 16'd1;
		end
	endtask

	// watchdog
	initial begin
		#360000;
		n_mismatch++;
		close_out();
	end

	// main sequence
	initial begin
		logic [15:0] c;
		logic [7:0]  d;
		clk = 1'b0; rst_b = 1'b0; sag = 1'b0; wr = 1'b0; rd = 1'b0;
		addr = 5'h00; wdata = 8'h00; win_cnt = 16'd0; n_mismatch = 0; checked = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		// 1 Hz output starts in its low half
		cmp8({7'h00, pin}, 8'h00);
		chk(IDX_ST1, 8'h01);
		chk(IDX_ST1, 8'h00);
		for (int i = 0; i < 17; i++) chk(por_a[i], por_v[i]);
		for (int i = 0; i < 13; i++) begin
			if (i == 10) wr_reg(IDX_ST1, 8'h40);
			wr_reg(cal_a[i], cal_w[i]);
			chk(cal_a[i], cal_e[i]);
		end
		wr_reg(IDX_MON, 8'h02);
		wr_reg(IDX_DAY, 8'h30);
		chk(IDX_DAY, 8'h01);
		chk(IDX_MON, 8'h03);
		wr_chk(IDX_SCRATCH, 8'h5A, 8'h5A);
		wr_chk(IDX_SCRATCH, 8'hA5, 8'hA5);
		wr_reg(IDX_CORR, 8'h00);
		chk(IDX_CORR, 8'h00);
		wr_reg(5'h1F, 8'h77);
		chk(5'h1F, 8'h00);
		// user frequencies on the pin
		wr_chk(IDX_A1, 8'h0F, 8'h0F);
		low_cnt(8192, c);
		cmpn(c, 16'd4096);
		wr_reg(IDX_A1, 8'h18);
		low_cnt(8192, c);
		cmpn(c, 16'd6144);
		wr_reg(IDX_A1, 8'h00);
		low_cnt(8192, c);
		cmpn(c, 16'd0);
		// crystal clock mode needs no alarm contents
		wr_reg(IDX_ST2, 8'h10);
		low_cnt(64, c);
		cmpn(c, 16'd32);
		// alarm two overrides the frequency mode
		wr_reg(IDX_ST2, 8'h82);
		wr_reg(IDX_A2, 8'h01);
		repeat (3) @(posedge clk);
		cmp8({7'h00, pin}, 8'h00);
		wr_reg(IDX_A2, 8'h00);
		wr_reg(IDX_ST2, 8'h80);
		repeat (3) @(posedge clk);
		cmp8({7'h00, pin}, 8'h01);
		cmpn(16'(win_cnt >= LOWV_WIN_TICKS - 16'd4 && win_cnt <= LOWV_WIN_TICKS + 16'd4),
			16'd1);
		// supply sag at the next sampling window
		wr_reg(IDX_A1, 8'h80);
		wr_reg(IDX_SEC, 8'h65);
		sag <= 1'b1;
		for (int k = 0; k < 70000 && smp !== 1'b1; k++) @(posedge clk);
		cmp8({7'h00, smp}, 8'h01);
		cmp8({7'h00, pin}, 8'h00);
		repeat (10) @(posedge clk);
		cmp8({7'h00, smp}, 8'h00);
		sag <= 1'b0;
		repeat (4) @(posedge clk);
		rd_reg(IDX_ST1, d);
		cmp8(d & 8'h02, 8'h02);
		chk(IDX_SEC, 8'h00);
		chk(IDX_MIN, 8'h01);
		chk(IDX_SCRATCH, 8'hA5);
		// alarm one on the hour byte alone, 24-hour mode, hour 05 before noon
		wr_reg(IDX_A1, 8'h00);
		wr_reg(IDX_ST2, 8'h20);
		wr_reg(5'h0A, 8'h0B);
		repeat (3) @(posedge clk);
		cmp8({7'h00, pin}, 8'h00);
		rd_reg(IDX_ST1, d);
		cmp8(d & 8'h08, 8'h08);
		// software initialization
		wr_reg(IDX_YEAR, 8'h55);
		wr_reg(IDX_ST1, 8'hF0);
		chk(IDX_ST1, 8'h70);
		for (int i = 0; i < 17; i++)
			chk(por_a[i], (por_a[i] == IDX_ST2 || por_a[i] == IDX_A1) ? 8'h00 : por_v[i]);
		cmp8({7'h00, pin}, 8'h01);
		close_out();
	end
endmodule // rtc_core_bench
`default_nettype wire
